// file: hw/lin_table_consts.svh
// How it works
// - Segment count ranges one to sixteen; each accepted add press adds one segment.
// - Insert places a new segment just ahead of the shown index.
// - Insert keeps stored values; later segments move up one index.
// - Remove deletes the shown segment; later segments move down one.
// - Current index and segment total are shown during insert and remove.
// - Insert below segment zero only if its start frequency exceeds zero.
// - Each segment stores a start frequency in hertz.
// - Frequency not strictly between its neighbours raises an order fault.
// - Pulse count is divided by the active segment divisor.
// - Divisor accepted only from 0.0001 to 99999 inclusive.
// - Divisor point sits between any digits or after the last one.
// - Copy replicates table A into table b, then signals completion.
// - Two independent identical tables exist, one per channel.
// - Tables apply only in linearised mode; contents kept on mode change. Linear mode still outputs each table's segment 0 divisor.
// - Defaults: one segment 0 Hz to 5000 Hz, both divisors 1.00.
`ifndef LIN_TABLE_CONSTS_SVH
`define LIN_TABLE_CONSTS_SVH
`define LT_MAX_SEG 5'd16
`define LT_NUM_BP 17
`define LT_DEF_TOP_FREQ 20'h01388
`define LT_DEF_DIV_MANT 17'h00064
`define LT_DEF_DIV_DP 3'h2
`define LT_DIV_MIN_MANT 17'h00001
`define LT_DIV_MAX_MANT 17'h1869F
`define LT_DP_MAX 3'h4
`define LT_DP_FRAC_MAX 3'h4
`define LT_DONE_CYCLES 4'hF
`endif

// file: hw/lin_table_pkg.sv
package lin_table_pkg;
   typedef logic [19:0] freq_t;
   typedef logic [16:0] mant_t;
   typedef logic [2:0] dp_t;
   typedef logic [3:0] idx_t;
   typedef logic [4:0] cnt_t;
   typedef enum logic [2:0] {OP_NONE, OP_ADD, OP_DEL, OP_FREQ, OP_DIV} op_e;
endpackage

// file: hw/lin_channel.sv
`timescale 1ns/100ps
`default_nettype none
`include "lin_table_consts.svh"
// One channel table of breakpoints; breakpoint i starts segment i, the last ends the top one.
module lin_channel
   import lin_table_pkg::*;
(
   input wire logic sys_clk_i,
   input wire logic rst_i,
   input wire logic defaults_i,
   input wire lin_table_pkg::op_e op_i,
   input wire lin_table_pkg::idx_t sel_i,
   input wire lin_table_pkg::freq_t freq_i,
   input wire lin_table_pkg::mant_t mant_i,
   input wire lin_table_pkg::dp_t dp_i,
   input wire logic load_i,
   input wire lin_table_pkg::freq_t load_freq_i [`LT_NUM_BP],
   input wire lin_table_pkg::mant_t load_mant_i [`LT_NUM_BP],
   input wire lin_table_pkg::dp_t load_dp_i [`LT_NUM_BP],
   input wire lin_table_pkg::cnt_t load_cnt_i,
   output var lin_table_pkg::freq_t freq_o [`LT_NUM_BP],
   output var lin_table_pkg::mant_t mant_o [`LT_NUM_BP],
   output var lin_table_pkg::dp_t dp_o [`LT_NUM_BP],
   output var lin_table_pkg::cnt_t cnt_o,
   output logic refused_o,
   output logic fault_o
);
   freq_t fr [`LT_NUM_BP];
   mant_t mt [`LT_NUM_BP];
   dp_t dp [`LT_NUM_BP];
   cnt_t cnt;
   logic fault_ok;
   logic div_ok;
   logic add_ok;
   logic del_ok;

   // Ordering check against both neighbours of the breakpoint being edited.
   always_comb
   begin
      fault_ok = 1'b1;
      if (sel_i != 4'h0 && freq_i <= fr[sel_i - 4'h1])
         fault_ok = 1'b0;
      // The index is widened first so that breakpoint 15 meets 16 instead of wrapping to 0.
      if ({1'b0, sel_i} < cnt && freq_i >= fr[{1'b0, sel_i} + 5'h01])
         fault_ok = 1'b0;
   end

   // Divisor mantissa and point position must give 0.0001 to 99999.
   assign div_ok = mant_i >= `LT_DIV_MIN_MANT && mant_i <= `LT_DIV_MAX_MANT
      && dp_i <= `LT_DP_MAX;
   assign add_ok = cnt < `LT_MAX_SEG && (sel_i != 4'h0 || fr[0] != 20'h00000);
   assign del_ok = cnt > 5'd1 && {1'b0, sel_i} < cnt;

   // Table storage; insert shifts up, remove shifts down, values themselves untouched.
   // Breakpoint shifts are done by a generate so each entry picks neighbour or itself.
   for (genvar g = 0; g < `LT_NUM_BP; g++)
   begin : g_bp
      // Neighbour indices are clamped so that the end entries never name a missing slot.
      localparam int below = (g > 0) ? g - 1 : 0;
      localparam int above = (g < `LT_NUM_BP - 1) ? g + 1 : g;
      always_ff @(posedge sys_clk_i)
      begin
         if (rst_i || defaults_i)
         begin
            fr[g] <= (g == 1) ? `LT_DEF_TOP_FREQ : 20'h00000;
            mt[g] <= `LT_DEF_DIV_MANT;
            dp[g] <= `LT_DEF_DIV_DP;
         end
         else if (load_i)
         begin
            fr[g] <= load_freq_i[g];
            mt[g] <= load_mant_i[g];
            dp[g] <= load_dp_i[g];
         end
         else if (op_i == OP_ADD && add_ok)
         begin
            if (g > sel_i && g > 0)
            begin
               fr[g] <= fr[below];
               mt[g] <= mt[below];
               dp[g] <= dp[below];
            end
            else if (g == sel_i && sel_i == 4'h0)
               fr[g] <= 20'h00000; // New lowest segment starts at zero.
            else if (g == sel_i)
               fr[g] <= fr[below] + ((fr[g] - fr[below]) >> 1); // Midpoint keeps order legal.
         end
         else if (op_i == OP_DEL && del_ok)
         begin
            if (g >= sel_i && g < `LT_NUM_BP - 1)
            begin
               fr[g] <= fr[above];
               mt[g] <= mt[above];
               dp[g] <= dp[above];
            end
         end
         else if (op_i == OP_FREQ && g == sel_i && fault_ok)
            fr[g] <= freq_i;
         else if (op_i == OP_DIV && g == sel_i && div_ok)
         begin
            mt[g] <= mant_i;
            dp[g] <= dp_i;
         end
      end
   end

   // Segment count and the refusal and fault flags.
   always_ff @(posedge sys_clk_i)
   begin
      if (rst_i || defaults_i)
         cnt <= 5'd1;
      else if (load_i)
         cnt <= load_cnt_i;
      else if (op_i == OP_ADD && add_ok)
         cnt <= cnt + 5'd1;
      else if (op_i == OP_DEL && del_ok)
         cnt <= cnt - 5'd1;
   end

   always_ff @(posedge sys_clk_i)
   begin
      if (rst_i)
      begin
         refused_o <= 1'b0;
         fault_o <= 1'b0;
      end
      else
      begin
         refused_o <= (op_i == OP_ADD && !add_ok) || (op_i == OP_DEL && !del_ok)
            || (op_i == OP_DIV && !div_ok);
         fault_o <= op_i == OP_FREQ && !fault_ok;
      end
   end

   assign freq_o = fr;
   assign mant_o = mt;
   assign dp_o = dp;
   assign cnt_o = cnt;
endmodule
`default_nettype wire

// file: hw/piecewise_lineariser_table.sv
`timescale 1ns/100ps
`default_nettype none
`include "lin_table_consts.svh"
// Two lineariser tables with an editing port, copy A to b, and segment lookup.
module piecewise_lineariser_table
   import lin_table_pkg::*;
(
   input wire logic sys_clk_i,
   input wire logic rst_i,
   input wire logic defaults_i,
   input wire logic chan_sel_i,
   input wire lin_table_pkg::op_e op_i,
   input wire lin_table_pkg::idx_t seg_sel_i,
   input wire lin_table_pkg::freq_t breakpoint_frequency_i,
   input wire lin_table_pkg::mant_t segment_scale_divisor_i,
   input wire lin_table_pkg::dp_t divisor_point_i,
   input wire logic copy_first_to_second_i,
   input wire logic linearised_mode_i,
   input wire lin_table_pkg::freq_t meas_freq_a_i,
   input wire lin_table_pkg::freq_t meas_freq_b_i,
   output var lin_table_pkg::idx_t shown_seg_o,
   output var lin_table_pkg::cnt_t seg_total_o,
   output logic insert_refused_o,
   output logic breakpoint_order_fault_o,
   output logic copy_done_o,
   output logic lin_active_o,
   output var lin_table_pkg::mant_t div_mant_a_o,
   output var lin_table_pkg::dp_t div_point_a_o,
   output var lin_table_pkg::mant_t div_mant_b_o,
   output var lin_table_pkg::dp_t div_point_b_o
);
   freq_t fr [2][`LT_NUM_BP];
   mant_t mt [2][`LT_NUM_BP];
   dp_t dpv [2][`LT_NUM_BP];
   cnt_t cnt [2];
   logic refused [2];
   logic fault [2];
   op_e ch_op [2];
   logic copy_q;
   logic [3:0] done_cnt;

   // Finds the highest start frequency not above the input; first segment below that.
   function automatic idx_t find_seg(input freq_t f, input freq_t t [`LT_NUM_BP],
                                     input cnt_t n);
      idx_t r;
      r = 4'h0;
      for (int i = 1; i < `LT_NUM_BP - 1; i++)
         if (i < n && f >= t[i])
            r = i[3:0];
      return r;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Channel tables; only the selected channel sees the edit operation.
   for (genvar c = 0; c < 2; c++)
   begin : g_ch
      assign ch_op[c] = (chan_sel_i == 1'(c)) ? op_i : OP_NONE;
      lin_channel u_ch (
         .sys_clk_i(sys_clk_i),
         .rst_i(rst_i),
         .defaults_i(defaults_i),
         .op_i(ch_op[c]),
         .sel_i(seg_sel_i),
         .freq_i(breakpoint_frequency_i),
         .mant_i(segment_scale_divisor_i),
         .dp_i(divisor_point_i),
         .load_i(c == 1 && copy_q),
         .load_freq_i(fr[0]),
         .load_mant_i(mt[0]),
         .load_dp_i(dpv[0]),
         .load_cnt_i(cnt[0]),
         .freq_o(fr[c]),
         .mant_o(mt[c]),
         .dp_o(dpv[c]),
         .cnt_o(cnt[c]),
         .refused_o(refused[c]),
         .fault_o(fault[c])
      );
   end

   ////////////////////////////////////////////////////////////////////////////
   // Copy request is registered, then a done flag stands for a few cycles.
   always_ff @(posedge sys_clk_i)
   begin
      if (rst_i)
         copy_q <= 1'b0;
      else
         copy_q <= copy_first_to_second_i;
   end

   always_ff @(posedge sys_clk_i)
   begin
      if (rst_i)
      begin
         done_cnt <= 4'h0;
         copy_done_o <= 1'b0;
      end
      else if (copy_q)
      begin
         done_cnt <= `LT_DONE_CYCLES;
         copy_done_o <= 1'b1;
      end
      else
      begin
         if (done_cnt != 4'h0)
            done_cnt <= done_cnt - 4'h1;
         copy_done_o <= done_cnt > 4'h1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Display of shown segment and total for the selected channel, plus flags.
   always_ff @(posedge sys_clk_i)
   begin
      if (rst_i)
      begin
         shown_seg_o <= 4'h0;
         seg_total_o <= 5'd1;
         insert_refused_o <= 1'b0;
         breakpoint_order_fault_o <= 1'b0;
      end
      else
      begin
         shown_seg_o <= seg_sel_i;
         seg_total_o <= cnt[chan_sel_i];
         insert_refused_o <= refused[0] | refused[1];
         breakpoint_order_fault_o <= fault[0] | fault[1];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Divisor lookup; in linear mode the first segment's divisor is used, table kept.
   always_ff @(posedge sys_clk_i)
   begin
      if (rst_i)
      begin
         lin_active_o <= 1'b0;
         div_mant_a_o <= `LT_DEF_DIV_MANT;
         div_point_a_o <= `LT_DEF_DIV_DP;
         div_mant_b_o <= `LT_DEF_DIV_MANT;
         div_point_b_o <= `LT_DEF_DIV_DP;
      end
      else
      begin
         lin_active_o <= linearised_mode_i;
         if (linearised_mode_i)
         begin
            div_mant_a_o <= mt[0][find_seg(meas_freq_a_i, fr[0], cnt[0])];
            div_point_a_o <= dpv[0][find_seg(meas_freq_a_i, fr[0], cnt[0])];
            div_mant_b_o <= mt[1][find_seg(meas_freq_b_i, fr[1], cnt[1])];
            div_point_b_o <= dpv[1][find_seg(meas_freq_b_i, fr[1], cnt[1])];
         end
         else
         begin
            div_mant_a_o <= mt[0][0];
            div_point_a_o <= dpv[0][0];
            div_mant_b_o <= mt[1][0];
            div_point_b_o <= dpv[1][0];
         end
      end
   end
endmodule
`default_nettype wire

// file: verification/lin_table_chk.sv
`timescale 1ns/100ps
`default_nettype none
`include "lin_table_consts.svh"
// Ties table outputs to the edit requests that caused them.
module lin_table_chk
   import lin_table_pkg::*;
(
   input wire logic sys_clk_i,
   input wire logic rst_i,
   input wire logic defaults_i,
   input wire lin_table_pkg::op_e op_i,
   input wire logic copy_first_to_second_i,
   input wire logic linearised_mode_i,
   input wire lin_table_pkg::cnt_t seg_total_o,
   input wire logic insert_refused_o,
   input wire logic breakpoint_order_fault_o,
   input wire logic copy_done_o,
   input wire logic lin_active_o,
   input wire lin_table_pkg::mant_t div_mant_a_o,
   input wire lin_table_pkg::dp_t div_point_a_o
);
   default clocking @(posedge sys_clk_i);
   endclocking
   default disable iff (rst_i);
   a_reset_total: assert property ($fell(rst_i) |-> seg_total_o == 5'h01)
      else $error("total not one after reset");
   a_defaults_total: assert property (defaults_i |-> ##[1:3] seg_total_o == 5'h01)
      else $error("total not one after defaults");
   a_total_range: assert property (seg_total_o inside {[5'h01:`LT_MAX_SEG]})
      else $error("total out of range");
   a_div_range: assert property (div_mant_a_o inside {[`LT_DIV_MIN_MANT:`LT_DIV_MAX_MANT]})
      else $error("divisor out of range");
   a_point_range: assert property (div_point_a_o <= `LT_DP_MAX)
      else $error("point out of range");
   // Request is sampled, registered, then the done flag is registered: two edges back.
   a_copy_cause: assert property ($rose(copy_done_o) |->
      $past(copy_first_to_second_i, 2))
      else $error("copy done without request");
   a_copy_hold: assert property ($rose(copy_done_o) |-> copy_done_o [*8])
      else $error("copy done too short");
   a_fault_cause: assert property ($rose(breakpoint_order_fault_o) |->
      $past(op_i) == OP_FREQ || $past(op_i, 2) == OP_FREQ)
      else $error("fault without frequency edit");
   a_refuse_cause: assert property ($rose(insert_refused_o) |->
      $past(op_i) != OP_NONE || $past(op_i, 2) != OP_NONE)
      else $error("refusal without request");
   a_mode_off: assert property (!linearised_mode_i [*2] |-> !lin_active_o)
      else $error("lineariser active while off");
endmodule
bind piecewise_lineariser_table lin_table_chk i_chk (
   .sys_clk_i(sys_clk_i),
   .rst_i(rst_i),
   .defaults_i(defaults_i),
   .op_i(op_i),
   .copy_first_to_second_i(copy_first_to_second_i),
   .linearised_mode_i(linearised_mode_i),
   .seg_total_o(seg_total_o),
   .insert_refused_o(insert_refused_o),
   .breakpoint_order_fault_o(breakpoint_order_fault_o),
   .copy_done_o(copy_done_o),
   .lin_active_o(lin_active_o),
   .div_mant_a_o(div_mant_a_o),
   .div_point_a_o(div_point_a_o)
);
`default_nettype wire

// file: verification/panel_op.sv
`timescale 1ns/100ps
`default_nettype none
// Front-panel operator: one button press is one request for one clock.
module panel_op
   import lin_table_pkg::*;
(
   input wire logic sys_clk_i,
   output var lin_table_pkg::op_e op_o,
   output var lin_table_pkg::idx_t sel_o,
   output var lin_table_pkg::freq_t freq_o,
   output var lin_table_pkg::mant_t mant_o,
   output var lin_table_pkg::dp_t dp_o
);
   // Idle panel at time zero.
   initial
   begin
      op_o = OP_NONE;
      sel_o = 4'h0;
      freq_o = 20'h0;
      mant_o = 17'h0;
      dp_o = 3'h0;
   end
   // Frequency and mantissa are scrambled after release so a stale value is never mistaken for a live one; index and point are held.
   task automatic press(input op_e o, input idx_t s, input freq_t f, input mant_t m, input dp_t d);
      @(negedge sys_clk_i);
      op_o = o;
      sel_o = s;
      freq_o = f;
      mant_o = m;
      dp_o = d;
      @(negedge sys_clk_i);
      op_o = OP_NONE;
      freq_o = ~f;
      mant_o = ~m;
   endtask
endmodule
`default_nettype wire

// file: verification/testbench.sv
`timescale 1ns/100ps
`default_nettype none
// Edits the tables through the panel model and checks lookup and totals.
module testbench;
   import lin_table_pkg::*;
   logic sys_clk_i, rst_i, defaults_i, chan_sel_i, copy_i, mode_i, refd, flt, done, act;
   freq_t fa, fb, bf;
   op_e op;
   idx_t sel, shown;
   mant_t bm, ma, mb;
   dp_t bd, pa, pb;
   cnt_t tot;
   int n_fail, tests_run;
   panel_op i_panel_op (.sys_clk_i(sys_clk_i), .op_o(op), .sel_o(sel), .freq_o(bf),
      .mant_o(bm), .dp_o(bd));
   piecewise_lineariser_table i_piecewise_lineariser_table (.sys_clk_i(sys_clk_i),
      .rst_i(rst_i), .defaults_i(defaults_i), .chan_sel_i(chan_sel_i), .op_i(op),
      .seg_sel_i(sel), .breakpoint_frequency_i(bf), .segment_scale_divisor_i(bm),
      .divisor_point_i(bd), .copy_first_to_second_i(copy_i), .linearised_mode_i(mode_i),
      .meas_freq_a_i(fa), .meas_freq_b_i(fb), .shown_seg_o(shown), .seg_total_o(tot),
      .insert_refused_o(refd), .breakpoint_order_fault_o(flt), .copy_done_o(done),
      .lin_active_o(act), .div_mant_a_o(ma), .div_point_a_o(pa), .div_mant_b_o(mb),
      .div_point_b_o(pb));
   // Free-running 10 MHz clock.
   initial
   begin
      sys_clk_i = 1'b0;
      forever #50 sys_clk_i = ~sys_clk_i;
   end
   task automatic chk(input logic [19:0] s, input logic [19:0] e);
      tests_run++;
      if (s !== e)
      begin
         n_fail++;
         $display("CHECK FAILED at %0t seen %h expected %h", $time, s, e);
      end
   endtask
   task automatic st(input int n);
      repeat (n) @(negedge sys_clk_i);
   endtask
   // Press, then wait so that flags or totals have landed.
   task automatic p(input op_e o, input idx_t s, input freq_t f, input mant_t m, input dp_t d,
      input int w);
      i_panel_op.press(o, s, f, m, d);
      st(w);
   endtask
   task automatic lookup(input freq_t f, input mant_t m, input dp_t d);
      fa = f;
      st(3);
      chk(20'(ma), 20'(m));
      chk(20'(pa), 20'(d));
   endtask
   // Refusals, then both divisor limits accepted; segment 0 is put back to 1.00 at the end.
   task automatic t_refuse;
      chk(20'(tot), 20'h1);
      lookup(20'h00096, 17'h00064, 3'h2);
      p(OP_ADD, 4'h0, 20'h0, 17'h00064, 3'h2, 1);
      chk(20'(refd), 20'h1);
      p(OP_DEL, 4'h0, 20'h0, 17'h00064, 3'h2, 1);
      chk(20'(refd), 20'h1);
      p(OP_DIV, 4'h0, 20'h0, 17'h00000, 3'h0, 1);
      chk(20'(refd), 20'h1);
      p(OP_DIV, 4'h0, 20'h0, 17'h186A0, 3'h0, 1);
      chk(20'(refd), 20'h1);
      p(OP_DIV, 4'h0, 20'h0, 17'h00064, 3'h5, 1);
      chk(20'(refd), 20'h1);
      p(OP_DIV, 4'h0, 20'h0, 17'h1869F, 3'h0, 1);
      chk(20'(refd), 20'h0);
      p(OP_DIV, 4'h0, 20'h0, 17'h00001, 3'h4, 0);
      lookup(20'h00096, 17'h00001, 3'h4);
      p(OP_DIV, 4'h0, 20'h0, 17'h00064, 3'h2, 0);
   endtask
   task automatic t_insert;
      p(OP_FREQ, 4'h0, 20'h00064, 17'h0, 3'h0, 1);
      chk(20'(flt), 20'h0);
      p(OP_ADD, 4'h0, 20'h0, 17'h0, 3'h0, 2);
      chk(20'(tot), 20'h2);
      chk(20'(shown), 20'h0);
      lookup(20'h00096, 17'h00064, 3'h2);
      p(OP_FREQ, 4'h1, 20'h0, 17'h0, 3'h0, 1);
      chk(20'(flt), 20'h1);
      chk(20'(shown), 20'h1);
      p(OP_FREQ, 4'h1, 20'h01388, 17'h0, 3'h0, 1);
      chk(20'(flt), 20'h1);
   endtask
   task automatic t_divisor;
      p(OP_DIV, 4'h1, 20'h0, 17'h03039, 3'h1, 0);
      p(OP_DIV, 4'h0, 20'h0, 17'h00007, 3'h0, 0);
      lookup(20'h00096, 17'h03039, 3'h1);
      lookup(20'h00032, 17'h00007, 3'h0);
      mode_i = 1'b0;
      lookup(20'h00096, 17'h00007, 3'h0);
      chk(20'(act), 20'h0);
      mode_i = 1'b1;
      lookup(20'h00096, 17'h03039, 3'h1);
      chk(20'(act), 20'h1);
   endtask
   // Done rises on the same edge as the load and stands for fifteen cycles in all.
   task automatic t_copy;
      chan_sel_i = 1'b1;
      fb = 20'h00096;
      st(3);
      chk(20'(tot), 20'h1);
      chk(20'(mb), 20'h00064);
      copy_i = 1'b1;
      st(1);
      copy_i = 1'b0;
      repeat (20) if (done !== 1'b1) st(1);
      chk(20'(done), 20'h1);
      st(2);
      chk(20'(tot), 20'h2);
      chk(20'(mb), 20'h03039);
      chk(20'(pb), 20'h1);
      st(12);
      chk(20'(done), 20'h1);
      st(1);
      chk(20'(done), 20'h0);
      chan_sel_i = 1'b0;
   endtask
   task automatic t_remove_defaults;
      p(OP_DEL, 4'h0, 20'h0, 17'h0, 3'h0, 2);
      chk(20'(tot), 20'h1);
      lookup(20'h00032, 17'h03039, 3'h1);
      defaults_i = 1'b1;
      st(1);
      defaults_i = 1'b0;
      st(2);
      chk(20'(tot), 20'h1);
      lookup(20'h00032, 17'h00064, 3'h2);
      repeat (15) p(OP_ADD, 4'h1, 20'h0, 17'h0, 3'h0, 0);
      st(2);
      chk(20'(tot), 20'h10);
      p(OP_ADD, 4'h1, 20'h0, 17'h0, 3'h0, 1);
      chk(20'(refd), 20'h1);
   endtask
   task automatic give_verdict;
      $display("checks %0d mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   // Main sequence after ten cycles of reset.
   initial
   begin
      {rst_i, defaults_i, chan_sel_i, copy_i, mode_i} = 5'b10001;
      fa = 20'h0;
      fb = 20'h0;
      st(10);
      rst_i = 1'b0;
      t_refuse;
      t_insert;
      t_divisor;
      t_copy;
      t_remove_defaults;
      give_verdict;
   end
   // The run needs well under a thousand cycles; a hang is cut at ten thousand.
   initial
   begin
      #1000000;
      n_fail++;
      give_verdict;
   end
endmodule
`default_nettype wire
